// ==== hw/tbssm_pkg.sv ====
package tbssm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_AFI = 12'h004;
  localparam logic [11:0] REG_UID_LO = 12'h008;
  localparam logic [11:0] REG_UID_HI = 12'h00C;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_CMD = 12'h014;
  localparam logic [11:0] REG_ARG = 12'h018;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_FIELD_BIT = 0;
  localparam int AFI_LOCK_BIT = 8;
  localparam logic [7:0] AFI_RESET = 8'h00;
  localparam logic [31:0] UID_RESET = 32'h00000000;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  // ----------------------------------------------------------------
  // Command encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_REQ = 3'h1;
  localparam logic [2:0] CMD_SLOT = 3'h2;
  localparam logic [2:0] CMD_ATTRIB = 3'h3;
  localparam logic [2:0] CMD_HALT = 3'h4;
  localparam logic [2:0] CMD_DESEL = 3'h5;
  localparam logic [3:0] SLOT_CODE = 4'h5;
  localparam int PARAM_WAKE_BIT = 3;
  localparam logic [3:0] CID_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Response kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] RSP_NONE = 2'h0;
  localparam logic [1:0] RSP_ANSWER = 2'h1;
  localparam logic [1:0] RSP_HALTED = 2'h2;
  localparam logic [1:0] RSP_SELECTED = 2'h3;

  typedef enum logic [5:0] {
    ST_OFF = 6'b000001,
    ST_IDLE = 6'b000010,
    ST_WAIT = 6'b000100,
    ST_READY = 6'b001000,
    ST_HALT = 6'b010000,
    ST_ACTIVE = 6'b100000
  } tbssm_state_e;

  typedef struct packed {
    logic [2:0] kind;
    logic [7:0] code;
    logic [7:0] afi;
    logic [7:0] param;
    logic [31:0] pupi;
    logic [3:0] cid;
  } tbssm_cmd_s;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [31:0] pupi;
  } tbssm_rsp_s;

endpackage : tbssm_pkg

// ==== hw/tbssm_top.sv ====
// What this block does
// [RULE_01] Field entry starts in idle; field loss from anywhere goes off.
// [RULE_02] Entering idle sends no response.
// [RULE_03] Idle ignores all but request or wake-up with matching family.
// [RULE_04] Mismatched family request sends halt, ready or waiting to idle.
// [RULE_05] Go waiting only when slot count and random number both differ from one.
// [RULE_06] Waiting obeys only requests and slot markers; selecting request goes ready.
// [RULE_07] Slot marker equal to random number moves waiting to ready.
// [RULE_08] Every entry into ready sends an answer frame.
// [RULE_09] Ready takes request, select and halt; identifier match moves on.
// [RULE_10] Deselect with own card identifier moves active to halt.
// [RULE_11] Entering halt sends a confirming response.
// [RULE_12] Halt acts only on wake-up, leaving to idle, ready or waiting.
// [RULE_13] Active entered only from ready, with a confirming response.
// [RULE_14] Card identifier from select is stored and matched while active.
// [RULE_15] Family zero always matches; stored family is writable and lockable.
// [RULE_16] Request low nibble zero compares upper nibbles only.
// [RULE_17] Other family values must match all eight bits.
// [RULE_18] Parameter bit four selects request (0) or wake-up (1).
// [RULE_19] Master sends parameter bits five to eight as zero.
// [RULE_20] Parameter bits three to one code slot counts 1,2,4,8,16.
// [RULE_21] Slot count one sends matching cards straight to ready.
// [RULE_22] Fresh random number 1..N per request; answer only when it is one.
// [RULE_23] Slot marker: low nibble 0101, upper nibble slot minus one.
// [RULE_24] Card identifier is the low 32 bits of the unique identifier.
// [RULE_25] Reserved slot code is ignored: no state change, no response.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module tbssm_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rspValid,
  output logic [1:0] rspKind,
  output logic [31:0] rspPupi
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic afiMatch(input logic [7:0] req,
                                    input logic [7:0] own);
    if (req == 8'h00) begin
      afiMatch = 1'b1; // RULE_15
    end else if (req[3:0] == 4'h0) begin
      afiMatch = (req[7:4] == own[7:4]); // RULE_16
    end else begin
      afiMatch = (req == own); // RULE_17
    end
  endfunction

  // Slot count as a mask of N-1; reserved codes flagged
  function automatic logic [4:0] slotMask(input logic [2:0] code);
    case (code)
      3'h0: slotMask = 5'h00;
      3'h1: slotMask = 5'h01;
      3'h2: slotMask = 5'h03;
      3'h3: slotMask = 5'h07;
      3'h4: slotMask = 5'h0F;
      default: slotMask = 5'h10;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic fieldOn_q, fieldOn_d;
  logic [7:0] afi_q, afi_d;
  logic afiLock_q, afiLock_d;
  logic [31:0] uidLo_q, uidLo_d;
  logic [31:0] uidHi_q, uidHi_d;
  logic [31:0] arg_q, arg_d;
  logic [31:0] prdata_d;
  logic cmdStrobe;
  tbssm_pkg::tbssm_cmd_s cmd;

  wire logic wrEn = psel && penable && pwrite;
  wire logic rdEn = psel && penable && !pwrite;

  // Address decode used only by the error flag; both access paths decode paddr in their own case
  function automatic logic addrKnown(input logic [11:0] addr);
    case (addr)
      tbssm_pkg::REG_CTRL,
      tbssm_pkg::REG_AFI,
      tbssm_pkg::REG_UID_LO,
      tbssm_pkg::REG_UID_HI,
      tbssm_pkg::REG_STATUS,
      tbssm_pkg::REG_CMD,
      tbssm_pkg::REG_ARG: addrKnown = 1'b1;
      default: addrKnown = 1'b0;
    endcase
  endfunction

  wire logic known = addrKnown(paddr);

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  tbssm_pkg::tbssm_state_e state_q, state_d;
  logic [3:0] rnd_q, rnd_d;
  logic [3:0] cid_q, cid_d;
  logic [15:0] lfsr_q, lfsr_d;
  tbssm_pkg::tbssm_rsp_s rsp_q, rsp_d;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  assign cmdStrobe = wrEn && (paddr == tbssm_pkg::REG_CMD);

  always_comb begin
    cmd = '0;
    cmd.kind = pwdata[2:0];
    cmd.code = pwdata[15:8];
    cmd.afi = pwdata[23:16];
    cmd.param = pwdata[31:24];
    cmd.pupi = arg_q;
    cmd.cid = pwdata[7:4];
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_comb begin
    fieldOn_d = fieldOn_q;
    afi_d = afi_q;
    afiLock_d = afiLock_q;
    uidLo_d = uidLo_q;
    uidHi_d = uidHi_q;
    arg_d = arg_q;
    prdata_d = prdata;
    if (wrEn) begin
      case (paddr)
        tbssm_pkg::REG_CTRL: fieldOn_d = pwdata[tbssm_pkg::CTRL_FIELD_BIT];
        tbssm_pkg::REG_AFI: begin
          if (!afiLock_q) begin
            afi_d = pwdata[7:0]; // RULE_15
            afiLock_d = pwdata[tbssm_pkg::AFI_LOCK_BIT]; // RULE_15
          end
        end
        tbssm_pkg::REG_UID_LO: uidLo_d = pwdata;
        tbssm_pkg::REG_UID_HI: uidHi_d = pwdata;
        tbssm_pkg::REG_ARG: arg_d = pwdata;
        default: begin
        end
      endcase
    end
    if (rdEn) begin
      case (paddr)
        tbssm_pkg::REG_CTRL: prdata_d = {31'h00000000, fieldOn_q};
        tbssm_pkg::REG_AFI: prdata_d = {23'h000000, afiLock_q, afi_q};
        tbssm_pkg::REG_UID_LO: prdata_d = uidLo_q;
        tbssm_pkg::REG_UID_HI: prdata_d = uidHi_q;
        tbssm_pkg::REG_STATUS:
          prdata_d = {18'h00000, cid_q, rnd_q, state_q};
        tbssm_pkg::REG_ARG: prdata_d = arg_q;
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fieldOn_q <= 1'b0;
      afi_q <= tbssm_pkg::AFI_RESET;
      afiLock_q <= 1'b0;
      uidLo_q <= tbssm_pkg::UID_RESET;
      uidHi_q <= tbssm_pkg::UID_RESET;
      arg_q <= 32'h00000000;
      prdata <= 32'h00000000;
    end else begin
      fieldOn_q <= fieldOn_d;
      afi_q <= afi_d;
      afiLock_q <= afiLock_d;
      uidLo_q <= uidLo_d;
      uidHi_q <= uidHi_d;
      arg_q <= arg_d;
      prdata <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Anticollision state machine
  // ----------------------------------------------------------------
  logic isReq, isWake, match, reserved, pupiOk;
  logic [4:0] mask;
  logic [3:0] pick;
  logic reqSeen, wakeSeen, slotHit, attribHit, haltHit, deselHit;
  logic reqAnswer;
  tbssm_pkg::tbssm_state_e reqState;

  always_comb begin
    isReq = (cmd.kind == tbssm_pkg::CMD_REQ);
    isWake = cmd.param[tbssm_pkg::PARAM_WAKE_BIT]; // RULE_18
    match = afiMatch(cmd.afi, afi_q);
    mask = slotMask(cmd.param[2:0]); // RULE_20
    reserved = mask[4]; // RULE_25
    pick = (lfsr_q[3:0] & mask[3:0]) + 4'h1; // RULE_22
    pupiOk = (cmd.pupi == uidLo_q); // RULE_24
  end

  // ----------------------------------------------------------------
  // Command outcome, worked out once for every state that listens
  // ----------------------------------------------------------------
  always_comb begin
    // Reserved slot codes make the whole request vanish
    reqSeen = cmdStrobe && isReq && !reserved; // RULE_25
    wakeSeen = reqSeen && isWake; // RULE_12
    // Slot sixteen wraps to zero in four bits, just as R does
    slotHit = cmdStrobe &&
              (cmd.kind == tbssm_pkg::CMD_SLOT) &&
              (cmd.code[3:0] == tbssm_pkg::SLOT_CODE) &&
              (cmd.code[7:4] + 4'h1 == rnd_q); // RULE_23
    attribHit = cmdStrobe && pupiOk &&
                (cmd.kind == tbssm_pkg::CMD_ATTRIB); // RULE_09
    haltHit = cmdStrobe && pupiOk &&
              (cmd.kind == tbssm_pkg::CMD_HALT); // RULE_09
    deselHit = cmdStrobe &&
               (cmd.kind == tbssm_pkg::CMD_DESEL) &&
               (cmd.cid == cid_q); // RULE_14
    reqAnswer = 1'b0;
    if (!match) begin
      reqState = tbssm_pkg::ST_IDLE; // RULE_04
    end else if (mask == 5'h00 || pick == 4'h1) begin
      reqState = tbssm_pkg::ST_READY; // RULE_21 RULE_06
      reqAnswer = 1'b1; // RULE_08
    end else begin
      reqState = tbssm_pkg::ST_WAIT; // RULE_05
    end
  end

  // ----------------------------------------------------------------
  // Next state and response
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    rnd_d = rnd_q;
    cid_d = cid_q;
    rsp_d = rsp_q;
    rsp_d.valid = 1'b0;
    if (!fieldOn_q) begin
      state_d = tbssm_pkg::ST_OFF; // RULE_01
    end else begin
      // A command in the cycle that leaves OFF is dropped
      case (state_q)
        tbssm_pkg::ST_OFF: begin
          // Field entry always lands in idle, never higher
          state_d = tbssm_pkg::ST_IDLE; // RULE_01 RULE_02
        end
        tbssm_pkg::ST_IDLE: begin
          // A mismatch leaves the card idle and silent
          if (reqSeen && match) begin // RULE_03
            state_d = reqState;
            rnd_d = pick; // RULE_22
            if (reqAnswer) begin
              rsp_d.valid = 1'b1; // RULE_08
              rsp_d.kind = tbssm_pkg::RSP_ANSWER;
            end
          end
        end
        tbssm_pkg::ST_WAIT: begin
          if (reqSeen) begin // RULE_06
            state_d = reqState; // RULE_04
            if (match) begin
              rnd_d = pick; // RULE_22
            end
            if (reqAnswer) begin
              rsp_d.valid = 1'b1; // RULE_08
              rsp_d.kind = tbssm_pkg::RSP_ANSWER;
            end
          end else if (slotHit) begin
            state_d = tbssm_pkg::ST_READY; // RULE_07
            rsp_d.valid = 1'b1; // RULE_08
            rsp_d.kind = tbssm_pkg::RSP_ANSWER;
          end
        end
        tbssm_pkg::ST_READY: begin
          if (reqSeen) begin // RULE_09
            state_d = reqState; // RULE_04
            if (match) begin
              rnd_d = pick; // RULE_22
            end
            if (reqAnswer) begin
              rsp_d.valid = 1'b1; // RULE_08
              rsp_d.kind = tbssm_pkg::RSP_ANSWER;
            end
          end else if (attribHit) begin
            state_d = tbssm_pkg::ST_ACTIVE; // RULE_13
            cid_d = cmd.cid; // RULE_14
            rsp_d.valid = 1'b1; // RULE_13
            rsp_d.kind = tbssm_pkg::RSP_SELECTED;
          end else if (haltHit) begin
            state_d = tbssm_pkg::ST_HALT; // RULE_09
            rsp_d.valid = 1'b1; // RULE_11
            rsp_d.kind = tbssm_pkg::RSP_HALTED;
          end
        end
        tbssm_pkg::ST_HALT: begin
          // A plain request is not enough to wake a parked card
          if (wakeSeen) begin // RULE_12
            state_d = reqState; // RULE_04
            if (match) begin
              rnd_d = pick; // RULE_22
            end
            if (reqAnswer) begin
              rsp_d.valid = 1'b1; // RULE_08
              rsp_d.kind = tbssm_pkg::RSP_ANSWER;
            end
          end
        end
        tbssm_pkg::ST_ACTIVE: begin
          // Requests are ignored here; only a deselect leaves
          if (deselHit) begin // RULE_14
            state_d = tbssm_pkg::ST_HALT; // RULE_10
            rsp_d.valid = 1'b1; // RULE_11
            rsp_d.kind = tbssm_pkg::RSP_HALTED;
          end
        end
        default: begin
          state_d = tbssm_pkg::ST_OFF;
        end
      endcase
    end
    rsp_d.pupi = uidLo_q; // RULE_24
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= tbssm_pkg::ST_OFF;
      rnd_q <= 4'h0;
      cid_q <= tbssm_pkg::CID_RESET;
      rsp_q <= '0;
    end else begin
      state_q <= state_d;
      rnd_q <= rnd_d;
      cid_q <= cid_d;
      rsp_q <= rsp_d;
    end
  end

  // ----------------------------------------------------------------
  // Pseudo-random source
  // ----------------------------------------------------------------
  // Free-running so the pick differs from one request to the next;
  // not truly random, so cards with one seed pick alike
  always_comb begin
    lfsr_d = {lfsr_q[14:0],
              lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lfsr_q <= tbssm_pkg::LFSR_SEED;
    end else begin
      lfsr_q <= lfsr_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rspValid = rsp_q.valid;
  assign rspKind = rsp_q.kind;
  assign rspPupi = rsp_q.pupi;

endmodule // tbssm_top

`default_nettype wire

// ==== sim/tbssm_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Response checks at the top ports
// ----------------------------------------------------------------
module tbssm_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rspValid,
  input wire logic [1:0] rspKind,
  input wire logic [31:0] rspPupi
);
  logic cmdWr;
  logic [2:0] kd;
  assign cmdWr = psel && penable && pwrite && paddr == tbssm_pkg::REG_CMD;
  assign kd = pwdata[2:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  only_cmd_a: assert property (rspValid |-> $past(cmdWr))
    else $error("response without a command");
  req_kind_a: assert property (cmdWr && kd == tbssm_pkg::CMD_REQ |=>
    !rspValid || rspKind == tbssm_pkg::RSP_ANSWER) else $error("bad kind");
  slot_kind_a: assert property (cmdWr && kd == tbssm_pkg::CMD_SLOT |=>
    !rspValid || rspKind == tbssm_pkg::RSP_ANSWER) else $error("bad kind");
  halt_kind_a: assert property (cmdWr && kd == tbssm_pkg::CMD_HALT |=>
    !rspValid || rspKind == tbssm_pkg::RSP_HALTED) else $error("bad kind");
  desel_kind_a: assert property (cmdWr && kd == tbssm_pkg::CMD_DESEL |=>
    !rspValid || rspKind == tbssm_pkg::RSP_HALTED) else $error("bad kind");
  attr_kind_a: assert property (cmdWr && kd == tbssm_pkg::CMD_ATTRIB |=>
    !rspValid || rspKind == tbssm_pkg::RSP_SELECTED) else $error("bad kind");
  resv_slots_a: assert property (cmdWr && kd == tbssm_pkg::CMD_REQ &&
    pwdata[26:24] > 3'h4 |=> !rspValid) else $error("reserved count answered");
  slot_code_a: assert property (cmdWr && kd == tbssm_pkg::CMD_SLOT &&
    pwdata[11:8] != tbssm_pkg::SLOT_CODE |=> !rspValid) else $error("bad slot");
  single_a: assert property (rspValid |=> !rspValid)
    else $error("response longer than one cycle");
endmodule // tbssm_chk

bind tbssm_top tbssm_chk u_chk (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rspValid(rspValid),
  .rspKind(rspKind), .rspPupi(rspPupi));
`default_nettype wire

// ==== sim/tbssm_reader.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Reader side: logs every frame the card sends
// ----------------------------------------------------------------
module tbssm_reader (
  input wire logic clk,
  input wire logic srst,
  input wire logic rspValid,
  input wire logic [1:0] rspKind,
  input wire logic [31:0] rspPupi,
  output logic [31:0] nFrames,
  output logic [1:0] lastKind,
  output logic [31:0] lastPupi
);
  // Counting frames catches a missing answer and a spurious one alike
  always_ff @(posedge clk) begin
    if (srst) begin
      nFrames <= 32'h0;
      lastKind <= 2'h0;
      lastPupi <= 32'h0;
    end else if (rspValid) begin
      nFrames <= nFrames + 32'h1;
      lastKind <= rspKind;
      lastPupi <= rspPupi;
    end
  end
endmodule // tbssm_reader
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module tb_top;
  localparam logic [31:0] PUPI = 32'h12345678;
  // {command word, 00 = own identifier in ARG, {state, response kind}}
  localparam logic [47:0] SEQ [19] = '{
    48'h00320001_00_08, 48'h00300001_00_21, 48'h00200001_00_08,
    48'h00000001_00_21, 48'h00210001_00_08, 48'h00310001_00_21,
    48'h05310001_00_20, 48'h07310001_00_20, 48'h00000004_01_20,
    48'h00000004_00_42, 48'h00310001_00_40, 48'h000000A3_00_40,
    48'h08310001_00_21, 48'h000000A3_01_20, 48'h000000A3_00_83,
    48'h08310001_00_80, 48'h00000035_00_80, 48'h000000A5_00_42,
    48'h08550001_00_08};
  logic clk, srst, psel, penable, pwrite, pready, pslverr, rspValid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rspPupi, rd, nFrames, lastPupi;
  logic [1:0] rspKind, lastKind;
  logic [3:0] r;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  tbssm_top u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rspValid(rspValid),
    .rspKind(rspKind), .rspPupi(rspPupi));
  tbssm_reader u_rdr (.clk(clk), .srst(srst), .rspValid(rspValid),
    .rspKind(rspKind), .rspPupi(rspPupi), .nFrames(nFrames),
    .lastKind(lastKind), .lastPupi(lastPupi));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic wrap_up;
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Read data lands one cycle after the access edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    rd = prdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input logic [31:0] c, input logic [7:0] a,
                      input logic [7:0] e);
    logic [31:0] n0;
    n0 = nFrames;
    apb(1'b1, tbssm_pkg::REG_ARG, (a == 8'h00) ? PUPI : ~PUPI);
    apb(1'b1, tbssm_pkg::REG_CMD, c);
    apb(1'b0, tbssm_pkg::REG_STATUS, 32'h0);
    chk("state", {26'h0, e[7:2]}, {26'h0, rd[5:0]});
    chk("frames", {31'h0, e[1:0] != 2'h0}, nFrames - n0);
    if (e[1:0] != 2'h0) begin
      chk("kind", {30'h0, e[1:0]}, {30'h0, lastKind});
      chk("pupi", PUPI, lastPupi);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    step(32'h00310001, 8'h00, 8'h04);
    apb(1'b1, tbssm_pkg::REG_UID_LO, PUPI);
    apb(1'b1, tbssm_pkg::REG_AFI, 32'h00000031);
    apb(1'b1, tbssm_pkg::REG_CTRL, 32'h00000001);
    step(32'h00000004, 8'h00, 8'h08);
    $display("test power done");
    for (int i = 0; i < 19; i++)
      step(SEQ[i][47:16], SEQ[i][15:8], SEQ[i][7:0]);
    $display("test sequence done");
    apb(1'b1, tbssm_pkg::REG_CMD, 32'h03310001);
    apb(1'b0, tbssm_pkg::REG_STATUS, 32'h0);
    r = rd[9:6];
    chk("r range", 32'h1, {31'h0, r >= 4'h1 && r <= 4'h8});
    chk("slot state", (r == 4'h1) ? 32'h8 : 32'h4, {26'h0, rd[5:0]});
    if (r != 4'h1) begin
      step({16'h0, r, 4'h5, 8'h02}, 8'h00, 8'h10);
      step({16'h0, r - 4'h1, 4'h6, 8'h02}, 8'h00, 8'h10);
      step(32'h00000004, 8'h00, 8'h10);
      step({16'h0, r - 4'h1, 4'h5, 8'h02}, 8'h00, 8'h21);
    end
    apb(1'b1, tbssm_pkg::REG_CMD, 32'h01310001);
    apb(1'b0, tbssm_pkg::REG_STATUS, 32'h0);
    chk("r two", 32'h1, {31'h0, rd[9:6] == 4'h1 || rd[9:6] == 4'h2});
    apb(1'b1, tbssm_pkg::REG_CTRL, 32'h0);
    step(32'h00310001, 8'h00, 8'h04);
    $display("test slots done");
    apb(1'b1, tbssm_pkg::REG_AFI, 32'h00000131);
    apb(1'b1, tbssm_pkg::REG_AFI, 32'h00000077);
    apb(1'b0, tbssm_pkg::REG_AFI, 32'h0);
    chk("afi lock", 32'h00000131, rd);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    $display("test registers done");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
